//--- hdl/ptc_consts.vh
// constants for the precision time clock time and rate register block
`ifndef PTC_CONSTS_VH
`define PTC_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PTC_OFS_CONTROL      11'h600
`define PTC_OFS_NS_LOWER     11'h604
`define PTC_OFS_NS_UPPER     11'h606
`define PTC_OFS_SEC_LOWER    11'h608
`define PTC_OFS_SEC_UPPER    11'h60A
`define PTC_OFS_PHASE        11'h60C
`define PTC_OFS_RATE_LOWER   11'h610
`define PTC_OFS_RATE_UPPER   11'h612

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PTC_CTL_RESET_BIT    0
`define PTC_CTL_ENABLE_BIT   1
`define PTC_CTL_CONT_BIT     2
`define PTC_CTL_LOAD_BIT     3
`define PTC_CTL_CAPTURE_BIT  4
`define PTC_RATE_DIR_BIT     15
`define PTC_NS_UPPER_MSB     13
`define PTC_PHASE_MSB        2
`define PTC_RATE_UPPER_MSB   13

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PTC_RST_WORD         16'h0000
`define PTC_RST_ENABLE       1'b1

// ----------------------------------------------------------------------
// timing figures, in ns, and the last sub-phase code
// ----------------------------------------------------------------------
`define PTC_CLK_PERIOD_NS    25
`define PTC_REF_PERIOD_NS    40
`define PTC_SUBSTEP_NS       8
`define PTC_NS_PER_SEC       30'd1000000000
`define PTC_SUBPHASE_LAST    3'h4

`endif

//--- hdl/ptc_ref_divider.v
// reference period divider and 8 ns sub-phase tracker
`timescale 1ns/100ps
`include "ptc_consts.vh"

module ptc_ref_divider (
   input  wire       clk,
   input  wire       arst_n,
   input  wire       run,         // clock enabled
   input  wire       load,        // force position from load_phase
   input  wire [2:0] load_phase,  // sub-phase to load
   output reg        ref_tick,    // one-cycle pulse, once per 40 ns
   output wire [2:0] sub_phase    // current 8 ns slot, 0 to 4
);

   // ----------------------------------------------------------------------
   // constants derived from the clock and reference periods
   // ----------------------------------------------------------------------
   localparam [5:0] STEP_NS = `PTC_CLK_PERIOD_NS;  // time per system clock
   localparam [5:0] REF_NS  = `PTC_REF_PERIOD_NS;  // one reference period
   localparam [5:0] SUB_NS  = `PTC_SUBSTEP_NS;     // one sub-phase slot

   reg  [5:0] pos_reg;   // ns elapsed inside the reference period
   reg  [5:0] pos_next;
   reg        tick_next;
   wire [6:0] pos_sum;   // elapsed plus one clock period
   wire [5:0] pos_div;   // slot index before clamping

   assign pos_sum   = {1'b0, pos_reg} + {1'b0, STEP_NS};
   // the 40 ns period is not a whole number of 25 ns clocks, so the
   // position walks fractionally and the slot is derived from it
   assign pos_div   = pos_reg / SUB_NS;
   assign sub_phase = (pos_div > 6'd4) ? `PTC_SUBPHASE_LAST
                                       : pos_div[2:0];

   // ----------------------------------------------------------------------
   // next position; a load places the period at the loaded slot
   // ----------------------------------------------------------------------
   always @* begin
      pos_next  = pos_reg;
      tick_next = 1'b0;
      if (load) begin
         // unused codes fall back to slot zero
         pos_next = (load_phase > `PTC_SUBPHASE_LAST) ? 6'd0
                                                      : {load_phase, 3'b000};
      end else if (run) begin
         if (pos_sum >= {1'b0, REF_NS}) begin
            pos_next  = pos_sum[5:0] - REF_NS;
            tick_next = 1'b1;  // one reference period has passed
         end else begin
            pos_next  = pos_sum[5:0];
         end
      end
      // the tick leaves unregistered so the count and the slot move at
      // the same edge; a registered tick left the count one clock behind
      // the wrapped slot and a capture there read 40 ns short
      ref_tick  = tick_next;
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_reg  <= 6'd0;
      end else begin
         pos_reg  <= pos_next;
      end
   end

endmodule // ptc_ref_divider

//--- hdl/ptc_time_rate.v
// time and rate registers of the precision time clock
//
// Function
// - ns bits 29:16 in upper word, reset zero
// - 32-bit seconds in two 16-bit words
// - update every 40 ns, track 8 ns slot
// - phase codes 0..4 are 0..32 ns
// - time word write clears phase field
// - 30-bit rate trim over two words
// - trim adds or subtracts per direction bit
// - zero trim disables all frequency adjustment
// - ns bits 15:0 in lower word
// - capture command snapshots running clock
// - load command loads clock from registers
// - continuous enable applies trim every 40 ns period
`timescale 1ns/100ps
`include "ptc_consts.vh"

module ptc_time_rate (
   input  wire        CLOCK,      // 40 MHz system clock
   input  wire        ARST_N,     // asynchronous reset, active low
   input  wire [10:0] REG_ADDR,   // register byte address
   input  wire [15:0] REG_WDATA,  // write data
   input  wire        REG_WR,     // write strobe, one cycle
   input  wire        REG_RD,     // read strobe, one cycle
   output reg  [15:0] REG_RDATA   // read data, valid the cycle after REG_RD
);

   // ----------------------------------------------------------------------
   // host-visible registers
   // ----------------------------------------------------------------------
   reg  [15:0] ns_lower_reg;      // time_nanoseconds_lower
   reg  [13:0] ns_upper_reg;      // time_nanoseconds_upper
   reg  [15:0] sec_lower_reg;     // time_seconds_lower
   reg  [15:0] sec_upper_reg;     // time_seconds_upper
   reg  [2:0]  phase_reg;         // time_subcycle_phase
   reg  [15:0] rate_lower_reg;    // rate_trim_lower
   reg  [13:0] rate_upper_reg;    // rate_trim_upper
   reg         rate_dir_reg;      // rate_trim_direction
   reg         cont_adj_reg;      // continuous_adjust_enable
   reg         enable_reg;        // clock runs while set

   // ----------------------------------------------------------------------
   // running clock
   // ----------------------------------------------------------------------
   reg  [29:0] rtc_ns_reg;        // nanoseconds
   reg  [31:0] rtc_sub_reg;       // fraction of ns, 2^-32 ns units
   reg  [31:0] rtc_sec_reg;       // seconds
   reg  [29:0] rtc_ns_next;
   reg  [31:0] rtc_sub_next;
   reg  [31:0] rtc_sec_next;

   wire        ref_tick;          // one pulse per reference period
   wire [2:0]  sub_phase;         // current 8 ns slot
   wire [29:0] rate_value;        // full trim value
   wire        trim_on;           // trim is applied this period
   wire [61:0] acc_now;           // ns and fraction side by side
   wire [61:0] acc_step;          // acc plus one reference period
   wire [61:0] acc_adj;           // after the trim

   localparam [29:0] REF_PERIOD = `PTC_REF_PERIOD_NS;  // ns added per tick

   // ----------------------------------------------------------------------
   // decoded host strobes
   // ----------------------------------------------------------------------
   wire wr_ctl    = REG_WR && (REG_ADDR == `PTC_OFS_CONTROL);
   wire wr_nsl    = REG_WR && (REG_ADDR == `PTC_OFS_NS_LOWER);
   wire wr_nsh    = REG_WR && (REG_ADDR == `PTC_OFS_NS_UPPER);
   wire wr_secl   = REG_WR && (REG_ADDR == `PTC_OFS_SEC_LOWER);
   wire wr_sech   = REG_WR && (REG_ADDR == `PTC_OFS_SEC_UPPER);
   wire wr_phase  = REG_WR && (REG_ADDR == `PTC_OFS_PHASE);
   wire wr_ratel  = REG_WR && (REG_ADDR == `PTC_OFS_RATE_LOWER);
   wire wr_rateh  = REG_WR && (REG_ADDR == `PTC_OFS_RATE_UPPER);
   wire time_wr   = wr_nsl | wr_nsh | wr_secl | wr_sech;
   // self-clearing commands act in the write cycle and never store
   wire cmd_cap   = wr_ctl && REG_WDATA[`PTC_CTL_CAPTURE_BIT];
   wire cmd_load  = wr_ctl && REG_WDATA[`PTC_CTL_LOAD_BIT];
   wire cmd_reset = wr_ctl && REG_WDATA[`PTC_CTL_RESET_BIT];

   // ----------------------------------------------------------------------
   // reference divider and sub-phase tracker
   // ----------------------------------------------------------------------
   ptc_ref_divider u_div (
      .clk        (CLOCK),
      .arst_n     (ARST_N),
      .run        (enable_reg),
      .load       (cmd_load | cmd_reset),
      .load_phase (cmd_reset ? 3'h0 : phase_reg),
      .ref_tick   (ref_tick),
      .sub_phase  (sub_phase)
   );

   // ----------------------------------------------------------------------
   // per-period advance
   // ----------------------------------------------------------------------
   assign rate_value = {rate_upper_reg, rate_lower_reg};
   // a zero trim overrides the enable bit
   assign trim_on    = cont_adj_reg && (rate_value != 30'd0);
   assign acc_now    = {rtc_ns_reg, rtc_sub_reg};
   assign acc_step   = acc_now + {REF_PERIOD, 32'd0};
   // direction 0 speeds the clock up, 1 slows it down; the trim is
   // under a quarter ns so the decrement can never borrow past zero
   assign acc_adj    = !trim_on     ? acc_step :
                       rate_dir_reg ? acc_step - {32'd0, rate_value}
                                    : acc_step + {32'd0, rate_value};

   // ----------------------------------------------------------------------
   // running clock next value: reset, load, then normal advance
   // ----------------------------------------------------------------------
   always @* begin
      rtc_ns_next  = rtc_ns_reg;
      rtc_sub_next = rtc_sub_reg;
      rtc_sec_next = rtc_sec_reg;
      if (cmd_reset) begin
         rtc_ns_next  = 30'd0;
         rtc_sub_next = 32'd0;
         rtc_sec_next = 32'd0;
      end else if (cmd_load) begin
         // host staged all words before setting the command
         rtc_ns_next  = {ns_upper_reg, ns_lower_reg};
         rtc_sub_next = 32'd0;
         rtc_sec_next = {sec_upper_reg, sec_lower_reg};
      end else if (ref_tick && enable_reg) begin
         rtc_sub_next = acc_adj[31:0];
         if (acc_adj[61:32] >= `PTC_NS_PER_SEC) begin
            // fraction is untouched so trim stays continuous
            rtc_ns_next  = acc_adj[61:32] - `PTC_NS_PER_SEC;
            rtc_sec_next = rtc_sec_reg + 32'd1;
         end else begin
            rtc_ns_next  = acc_adj[61:32];
         end
      end
   end

   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rtc_ns_reg  <= 30'd0;
         rtc_sub_reg <= 32'd0;
         rtc_sec_reg <= 32'd0;
      end else begin
         rtc_ns_reg  <= rtc_ns_next;
         rtc_sub_reg <= rtc_sub_next;
         rtc_sec_reg <= rtc_sec_next;
      end
   end

   // ----------------------------------------------------------------------
   // time words: host writes, capture snapshot
   // ----------------------------------------------------------------------
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ns_lower_reg  <= `PTC_RST_WORD;
         ns_upper_reg  <= 14'h0000;
         sec_lower_reg <= `PTC_RST_WORD;
         sec_upper_reg <= `PTC_RST_WORD;
         phase_reg     <= 3'h0;
      end else if (cmd_cap) begin
         // snapshot of the running clock for reading
         ns_lower_reg  <= rtc_ns_reg[15:0];
         ns_upper_reg  <= rtc_ns_reg[29:16];
         sec_lower_reg <= rtc_sec_reg[15:0];
         sec_upper_reg <= rtc_sec_reg[31:16];
         phase_reg     <= sub_phase;
      end else begin
         if (wr_nsl) begin
            ns_lower_reg <= REG_WDATA;
         end
         if (wr_nsh) begin
            ns_upper_reg <= REG_WDATA[`PTC_NS_UPPER_MSB:0];
         end
         if (wr_secl) begin
            sec_lower_reg <= REG_WDATA;
         end
         if (wr_sech) begin
            sec_upper_reg <= REG_WDATA;
         end
         if (time_wr) begin
            phase_reg <= 3'h0;
         end else if (wr_phase) begin
            phase_reg <= REG_WDATA[`PTC_PHASE_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // rate and control words
   // ----------------------------------------------------------------------
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rate_lower_reg <= `PTC_RST_WORD;
         rate_upper_reg <= 14'h0000;
         rate_dir_reg   <= 1'b0;
         cont_adj_reg   <= 1'b0;
         enable_reg     <= `PTC_RST_ENABLE;
      end else begin
         if (wr_ratel) begin
            rate_lower_reg <= REG_WDATA;
         end
         if (wr_rateh) begin
            rate_upper_reg <= REG_WDATA[`PTC_RATE_UPPER_MSB:0];
            rate_dir_reg   <= REG_WDATA[`PTC_RATE_DIR_BIT];
         end
         if (wr_ctl) begin
            cont_adj_reg <= REG_WDATA[`PTC_CTL_CONT_BIT];
            enable_reg   <= REG_WDATA[`PTC_CTL_ENABLE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------------
   // read data: registered, unmapped and reserved bits read zero
   // ----------------------------------------------------------------------
   always @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `PTC_OFS_CONTROL:    REG_RDATA <= {13'h0000, cont_adj_reg, enable_reg, 1'b0};
            `PTC_OFS_NS_LOWER:   REG_RDATA <= ns_lower_reg;
            `PTC_OFS_NS_UPPER:   REG_RDATA <= {2'b00, ns_upper_reg};
            `PTC_OFS_SEC_LOWER:  REG_RDATA <= sec_lower_reg;
            `PTC_OFS_SEC_UPPER:  REG_RDATA <= sec_upper_reg;
            `PTC_OFS_PHASE:      REG_RDATA <= {13'h0000, phase_reg};
            `PTC_OFS_RATE_LOWER: REG_RDATA <= rate_lower_reg;
            `PTC_OFS_RATE_UPPER: REG_RDATA <= {rate_dir_reg, 1'b0, rate_upper_reg};
            default:             REG_RDATA <= 16'h0000;
         endcase
      end
   end

endmodule // ptc_time_rate

//--- test/ptc_time_rate_asserts.sv
// checker for the register port behaviour of the time and rate block
`timescale 1ns/100ps
`include "ptc_consts.vh"

module ptc_time_rate_asserts (
   input logic        CLOCK,
   input logic        ARST_N,
   input logic [10:0] REG_ADDR,
   input logic [15:0] REG_WDATA,
   input logic        REG_WR,
   input logic        REG_RD,
   input logic [15:0] REG_RDATA
);
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   wire mapped    = REG_ADDR inside {11'h600, 11'h604, 11'h606, 11'h608,
                                     11'h60A, 11'h60C, 11'h610, 11'h612};
   wire time_word = REG_ADDR inside {11'h604, 11'h606, 11'h608, 11'h60A};
   wire wr_only   = REG_WR && !REG_RD;  // a pure write cycle
   wire rd_only   = REG_RD && !REG_WR;  // a pure read cycle

   // bits that read back as written; control is kept out because its
   // command bits clear themselves
   function automatic logic [15:0] ptc_mask(input logic [10:0] a);
      case (a)
         11'h606: ptc_mask = 16'h3FFF;
         11'h60C: ptc_mask = 16'h0007;
         11'h612: ptc_mask = 16'hBFFF;
         default: ptc_mask = 16'hFFFF;
      endcase
   endfunction

   default clocking ptc_cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   // ------------------------------------------------------------
   // port relations
   // ------------------------------------------------------------
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_ctl_self_clear: assert property (REG_RD && REG_ADDR == 11'h600
      |=> (REG_RDATA & 16'hFFF9) == 16'h0000)
      else $error("control command bits read back set");
   a_ns_upper_resv: assert property (REG_RD && REG_ADDR == 11'h606
      |=> REG_RDATA[15:14] == 2'b00)
      else $error("ns upper spare bits set");
   a_phase_resv: assert property (REG_RD && REG_ADDR == 11'h60C
      |=> REG_RDATA[15:3] == 13'h0000)
      else $error("phase spare bits set");
   a_rate_hi_resv: assert property (REG_RD && REG_ADDR == 11'h612 |=> !REG_RDATA[14])
      else $error("rate upper bit 14 set");
   a_word_readback: assert property (
      (wr_only && mapped && REG_ADDR != 11'h600 ##1
      rd_only && $stable(REG_ADDR)) |=>
      REG_RDATA == ($past(REG_WDATA, 2) & ptc_mask($past(REG_ADDR, 2))))
      else $error("word did not read back as written");
   a_phase_cleared: assert property ((wr_only && time_word ##1 rd_only && REG_ADDR == 11'h60C)
      |=> REG_RDATA == 16'h0000)
      else $error("phase not cleared by time word write");
endmodule // ptc_time_rate_asserts

//--- test/ptc_time_rate_test.sv
// self-checking bench for the time and rate register block
`timescale 1ns/100ps
`include "ptc_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end

module ptc_time_rate_test;
   typedef struct packed {
      logic [10:0] wa; logic [15:0] wd; logic [10:0] ra; logic [15:0] ex;
   } ptc_row_t;
   logic        CLOCK, ARST_N, REG_WR, REG_RD;
   logic [10:0] REG_ADDR;
   logic [15:0] REG_WDATA;
   wire  [15:0] REG_RDATA;
   int          err_count, check_count;
   logic [15:0] ctl, d, sh, sl;   // control image keeps enable when commanding
   longint      t0, t1;
   // write, then read next cycle, and the word expected back
   ptc_row_t rows [16] = '{
      '{11'h604, 16'hA5A5, 11'h604, 16'hA5A5}, '{11'h606, 16'hFFFF, 11'h606, 16'h3FFF},
      '{11'h608, 16'h1234, 11'h608, 16'h1234}, '{11'h60A, 16'hFEDC, 11'h60A, 16'hFEDC},
      '{11'h610, 16'hFFFF, 11'h610, 16'hFFFF}, '{11'h612, 16'hFFFF, 11'h612, 16'hBFFF},
      '{11'h60C, 16'hFFFF, 11'h60C, 16'h0007}, '{11'h604, 16'h0001, 11'h60C, 16'h0000},
      '{11'h60C, 16'h0004, 11'h60C, 16'h0004}, '{11'h606, 16'h0001, 11'h60C, 16'h0000},
      '{11'h60C, 16'h0003, 11'h608, 16'h1234}, '{11'h60A, 16'h0002, 11'h60C, 16'h0000},
      '{11'h602, 16'hFFFF, 11'h602, 16'h0000}, '{11'h601, 16'hFFFF, 11'h601, 16'h0000},
      '{11'h600, 16'h0006, 11'h600, 16'h0006}, '{11'h600, 16'h0002, 11'h600, 16'h0002}};
   logic [10:0] regs [8] = '{11'h600, 11'h604, 11'h606, 11'h608,
                             11'h60A, 11'h60C, 11'h610, 11'h612};

   ptc_time_rate DUT (.CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

   // ------------------------------------------------------------
   // bus tasks: one idle edge between calls avoids double drives
   // ------------------------------------------------------------
   task automatic wr(input logic [10:0] a, input logic [15:0] v);
      @(posedge CLOCK);
      REG_ADDR  <= a;
      REG_WDATA <= v;
      REG_WR    <= 1'b1;
      @(posedge CLOCK);
      REG_WR    <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, output logic [15:0] v);
      @(posedge CLOCK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge CLOCK);
      REG_RD   <= 1'b0;
      #1 v = REG_RDATA;   // data lands after the taking edge
   endtask
   // back-to-back write and read, the tight case
   task automatic wrrd(input logic [10:0] wa, input logic [15:0] wd,
                       input logic [10:0] ra, output logic [15:0] v);
      @(posedge CLOCK);
      REG_ADDR  <= wa;
      REG_WDATA <= wd;
      REG_WR    <= 1'b1;
      @(posedge CLOCK);
      REG_WR    <= 1'b0;
      REG_RD    <= 1'b1;
      REG_ADDR  <= ra;
      @(posedge CLOCK);
      REG_RD    <= 1'b0;
      #1 v = REG_RDATA;
   endtask
   // capture and read the clock; takes exactly 12 edges
   task automatic snap(output longint t);
      logic [15:0] nl, nh;
      wr(11'h600, ctl | 16'h0010);
      rd(11'h604, nl);
      rd(11'h606, nh);
      rd(11'h608, sl);
      rd(11'h60A, sh);
      rd(11'h60C, d);
      `CHK(d[2:0] <= 3'h4, 1'b1)
      t = longint'({sh, sl}) * 1000000000 + longint'({nh[13:0], nl}) + 8 * d[2:0];
   endtask
   // elapsed time between captures n edges apart must fall in range
   task automatic gap(input int n, input longint lo, input longint hi);
      snap(t0);
      repeat (n - 12) @(posedge CLOCK);
      snap(t1);
      `CHK((t1 - t0 >= lo) && (t1 - t0 <= hi), 1'b1)
   endtask
   // load a time; the capture sees the clock 7 clocks (175 ns) after the
   // load edge, and the reported value trails by part of one 8 ns slot
   task automatic ld(input logic [29:0] ns, input logic [31:0] sec, input logic [2:0] ph);
      longint e;
      longint t;
      e = longint'(sec) * 1000000000 + ns + 8 * ph + 175;
      wr(11'h604, ns[15:0]);
      wr(11'h606, {2'b00, ns[29:16]});
      wr(11'h608, sec[15:0]);
      wr(11'h60A, sec[31:16]);
      wr(11'h60C, {13'h0000, ph});
      wr(11'h600, ctl | 16'h0008);
      repeat (6) @(posedge CLOCK);
      snap(t);
      `CHK((t >= e - 7) && (t <= e), 1'b1)
   endtask
   task summarize();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   initial begin
      repeat (10000) @(posedge CLOCK);
      err_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      summarize();
   end
   initial begin
      ARST_N      = 1'b0;
      REG_WR      = 1'b0;
      REG_RD      = 1'b0;
      REG_ADDR    = 11'h000;
      REG_WDATA   = 16'h0000;
      err_count   = 0;
      check_count = 0;
      ctl         = 16'h0002;
      repeat (20) @(posedge CLOCK);
      ARST_N <= 1'b1;
      foreach (rows[i]) begin
         wrrd(rows[i].wa, rows[i].wd, rows[i].ra, d);
         `CHK(d, rows[i].ex)
      end
      gap(80, 2000, 2000);
      ld(30'd1000, 32'd5, 3'd2);
      ld(30'h3B9A_C9D8, 32'h0001_FFFF, 3'd0);
      `CHK({sh, sl}, 32'h0002_0000)
      // large trim: 500 ticks of almost a quarter ns each
      wr(11'h612, 16'h3FFF);
      gap(800, 20000, 20000);
      ctl = 16'h0006;
      wr(11'h600, ctl);
      gap(800, 20109, 20141);
      wr(11'h612, 16'hBFFF);
      gap(800, 19859, 19891);
      wr(11'h610, 16'h0000);
      wr(11'h612, 16'h8000);
      gap(800, 20000, 20000);
      // clock reset command: from zero, one 25 ns clock reads as slot 3
      wr(11'h600, ctl | 16'h0001);
      snap(t0);
      `CHK(t0, 64'd24)
      // enable low freezes both the count and the slot
      ctl = 16'h0000;
      wr(11'h600, ctl);
      gap(80, 0, 0);
      // second reset in mid-run, then reset values
      @(posedge CLOCK) ARST_N <= 1'b0;
      repeat (2) @(posedge CLOCK);
      `CHK(REG_RDATA, 16'h0000)
      @(posedge CLOCK) ARST_N <= 1'b1;
      ctl = 16'h0002;
      foreach (regs[i]) begin
         rd(regs[i], d);
         `CHK(d, (regs[i] == 11'h600) ? 16'h0002 : 16'h0000)
      end
      summarize();
   end
endmodule // ptc_time_rate_test

bind ptc_time_rate ptc_time_rate_asserts u_chk (.CLOCK(CLOCK), .ARST_N(ARST_N),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA));
